// ===== src/gpc_pkg.sv
package gpc_pkg;
  // register indices; byte address is four times the index
  localparam logic [7:0] GPC_IDX_MAIN = 8'hE0;
  localparam logic [7:0] GPC_IDX_TIMER_CFG = 8'hE1;
  localparam logic [7:0] GPC_IDX_WAKE_RETURN = 8'hEB;
  localparam logic [7:0] GPC_IDX_SCRATCH_ONE = 8'hEC;
  localparam logic [7:0] GPC_IDX_SCRATCH_TWO = 8'hED;
  localparam logic [7:0] GPC_IDX_WAKE_CONTROL = 8'hEE;
  localparam logic [7:0] GPC_IDX_ACTIVITY_MODE = 8'hEF;
  localparam logic [7:0] GPC_IDX_IRQ_STATUS = 8'hF0;
  localparam logic [7:0] GPC_IDX_IRQ_MASK = 8'hF1;

  // main control/status field positions
  localparam int GPC_B_MODE_SEL = 7;
  localparam int GPC_B_PANEL_EN = 6;
  localparam int GPC_B_SMI_EN = 5;
  localparam int GPC_B_IRQ15_EN = 4;
  localparam int GPC_B_NORMAL = 3;
  localparam int GPC_B_TIMER = 2;
  localparam int GPC_B_EXT = 1;
  localparam int GPC_B_FORCE = 0;

  // timer configuration field positions
  localparam int GPC_B_FORCE_CMD = 3;
  localparam int GPC_F_TSEL_MSB = 2;

  // interrupt status bit positions
  localparam int GPC_B_EV_ENTRY = 0;
  localparam int GPC_B_EV_WAKE = 1;
  localparam int GPC_EV_W = 2;

  // reset values and the wake return write mask
  localparam logic [7:0] GPC_RST_CTRL = 8'h00;
  localparam logic [2:0] GPC_RST_TSEL = 3'h0;
  localparam logic [7:0] GPC_RST_PLAIN = 8'h00;
  localparam logic [1:0] GPC_RST_MASK = 2'h0;
  localparam logic [2:0] GPC_WAKE_RETURN_MASK = 3'h7;

  // timing
  localparam int GPC_CLK_HZ = 10_000_000;
  localparam int GPC_CLK_PERIOD_NS = 100;
  localparam int GPC_WAKE_DELAY_NS = 20;
  localparam int GPC_WAKE_DELAY_RAW = (GPC_WAKE_DELAY_NS + GPC_CLK_PERIOD_NS - 1) / GPC_CLK_PERIOD_NS;
  localparam int GPC_WAKE_DELAY_CYC = (GPC_WAKE_DELAY_RAW < 1) ? 1 : GPC_WAKE_DELAY_RAW;

  // idle period in seconds per selector code
  localparam logic [13:0] GPC_IDLE_SECS [0:7] = '{14'h000F, 14'h0078, 14'h012C, 14'h0384,
                                                  14'h0708, 14'h0A8C, 14'h0E10, 14'h3840};

  typedef enum logic [1:0] {
    GPC_ST_NORMAL = 2'b00,
    GPC_ST_LOW = 2'b01,
    GPC_ST_WAKING = 2'b10
  } gpc_state_t;
endpackage

// ===== src/gpc_sync.sv
`timescale 1ns/1ns
`default_nettype none
module gpc_sync #(
  parameter int W = 1
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic [W-1:0] d_in,
  output logic [W-1:0] q_out
);
  logic [W-1:0] meta_r;

  // two stages; only the second is visible outside
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      meta_r <= '0;
      q_out <= '0;
    end else begin
      meta_r <= d_in;
      q_out <= meta_r;
    end
  end
endmodule
`default_nettype wire

// ===== src/gpc_top.sv
`timescale 1ns/1ns
`default_nettype none
// Notes on behaviour
// - main bit 7: 0 autonomous low power, 1 interrupt-driven; resets 0.
// - bit 6 enables panel power output handling; resets 0.
// - bit 5 enables management interrupt output; resets 0.
// - bit 4 sends interrupt-driven events on line 15 instead.
// - bit 3 read-only: 0 low power, 1 normal; resets 1.
// - status bit returns to 1 shortly after wake-up event.
// - bit 2 write enables idle timer entry; write 0 blocks and clears flag.
// - bit 2 read: idle timer caused present entry.
// - bit 1 write enables request pin entry; write 0 blocks and clears flag.
// - bit 1 read: request pin caused present entry.
// - bit 0 write enables forced entry; write 0 disables and clears flag.
// - bit 0 read: software force caused present entry.
// - force command bit 3 enters low power when forced entry enabled.
// - idle period picked by three-bit code, 15 s up to 240 min.
module gpc_top
  import gpc_pkg::*;
#(
  parameter int TICKS_PER_SEC = GPC_CLK_HZ
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic [9:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic external_pm_request_in_n,
  input wire logic wake_event_in,
  input wire logic activity_in,
  output logic panel_power_enable_out_n,
  output logic system_mgmt_interrupt_out_n,
  output logic irq15_out,
  output logic irq_out,
  output logic low_power_state
);
  gpc_state_t state_r, state_nxt;
  logic [2:0] pins_s;
  logic ext_req_s, wake_s, act_s, ext_prev_r, ext_fall;
  logic ack_r, req, acc_wr, acc_rd;
  logic [7:0] idx;
  logic aligned;
  logic [3:0] mode_r;
  logic [2:0] en_r, flag_r, flag_set;
  logic normal_r;
  logic [2:0] tsel_r;
  logic [7:0] wret_r, scr1_r, scr2_r, wctl_r, amode_r;
  logic [GPC_EV_W-1:0] ev_st_r, ev_mask_r, ev_set;
  logic [23:0] presc_r;
  logic [13:0] secs_r;
  logic timer_hit, force_hit, ext_hit, enter, wake;
  logic [3:0] wdly_r;
  logic smi_pulse_r, irq15_r;
  logic [7:0] rd_byte;

  // pins cross into the clock domain first
  gpc_sync #(.W(3)) u_sync (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .d_in({activity_in, wake_event_in, ~external_pm_request_in_n}),
    .q_out(pins_s)
  );
  assign ext_req_s = pins_s[0];
  assign wake_s = pins_s[1];
  assign act_s = pins_s[2];

  // request pin acts on its asserting edge only
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      ext_prev_r <= 1'b0;
    end else begin
      ext_prev_r <= ext_req_s;
    end
  end
  assign ext_fall = ext_req_s & ~ext_prev_r;

  // bus slave: one wait cycle, then accept
  assign req = avs_read | avs_write;
  assign avs_waitrequest = req & ~ack_r;
  assign acc_wr = avs_write & ack_r;
  assign acc_rd = avs_read & ack_r;
  assign aligned = (avs_address[1:0] == 2'b00);
  assign idx = avs_address[9:2];

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= req & ~ack_r;
    end
  end

  // entry triggers, only taken from normal operation
  assign timer_hit = en_r[GPC_B_TIMER] && (secs_r >= GPC_IDLE_SECS[tsel_r]);
  assign force_hit = acc_wr && aligned && idx == GPC_IDX_TIMER_CFG
                     && avs_writedata[GPC_B_FORCE_CMD] && en_r[GPC_B_FORCE];
  assign ext_hit = en_r[GPC_B_EXT] && ext_fall;
  assign enter = (state_r == GPC_ST_NORMAL) && (timer_hit || force_hit || ext_hit);
  assign wake = (state_r == GPC_ST_LOW) && (wake_s || act_s);

  // one flag per entry, force first when several coincide
  always_comb begin
    flag_set = 3'h0;
    if (enter) begin
      if (force_hit) begin
        flag_set[GPC_B_FORCE] = 1'b1;
      end else if (ext_hit) begin
        flag_set[GPC_B_EXT] = 1'b1;
      end else begin
        flag_set[GPC_B_TIMER] = 1'b1;
      end
    end
  end

  // power state machine
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      GPC_ST_NORMAL: begin
        if (enter) begin
          state_nxt = GPC_ST_LOW;
        end
      end
      GPC_ST_LOW: begin
        if (wake) begin
          state_nxt = GPC_ST_WAKING;
        end
      end
      GPC_ST_WAKING: begin
        if (wdly_r == 4'(GPC_WAKE_DELAY_CYC - 1)) begin
          state_nxt = GPC_ST_NORMAL;
        end
      end
      default: state_nxt = GPC_ST_NORMAL;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      state_r <= GPC_ST_NORMAL;
    end else begin
      state_r <= state_nxt;
    end
  end

  // wake delay count; the status bit follows it
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      wdly_r <= 4'h0;
    end else if (state_r == GPC_ST_WAKING) begin
      wdly_r <= wdly_r + 4'h1;
    end else begin
      wdly_r <= 4'h0;
    end
  end

  // status bit driven by logic, never by a write
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      normal_r <= 1'b1;
    end else if (enter) begin
      normal_r <= 1'b0;
    end else if (state_r == GPC_ST_WAKING && state_nxt == GPC_ST_NORMAL) begin
      normal_r <= 1'b1;
    end
  end
  assign low_power_state = ~normal_r;

  // idle timer: seconds prescaler and counter, restarted by activity
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      presc_r <= 24'h000000;
      secs_r <= 14'h0000;
    end else if (act_s || state_r != GPC_ST_NORMAL || !en_r[GPC_B_TIMER] || enter) begin
      presc_r <= 24'h000000;
      secs_r <= 14'h0000;
    end else if (presc_r == 24'(TICKS_PER_SEC - 1)) begin
      presc_r <= 24'h000000;
      if (secs_r != 14'h3FFF) begin
        secs_r <= secs_r + 14'h0001;
      end
    end else begin
      presc_r <= presc_r + 24'h000001;
    end
  end

  // mode, output enables and entry enables of the main register
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      mode_r <= GPC_RST_CTRL[7:4];
      en_r <= GPC_RST_CTRL[2:0];
    end else if (acc_wr && aligned && idx == GPC_IDX_MAIN) begin
      mode_r <= avs_writedata[7:4];
      en_r <= avs_writedata[2:0];
    end
  end

  // entry flags: set wins over a clearing write
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      flag_r <= 3'h0;
    end else begin
      for (int i = 0; i < 3; i++) begin
        if (flag_set[i]) begin
          flag_r[i] <= 1'b1;
        end else if (acc_wr && aligned && idx == GPC_IDX_MAIN && !avs_writedata[i]) begin
          flag_r[i] <= 1'b0;
        end
      end
    end
  end

  // timer select; force command bit is a strobe, not stored
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      tsel_r <= GPC_RST_TSEL;
    end else if (acc_wr && aligned && idx == GPC_IDX_TIMER_CFG) begin
      tsel_r <= avs_writedata[GPC_F_TSEL_MSB:0];
    end
  end

  // plain storage registers
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      wret_r <= GPC_RST_PLAIN;
      scr1_r <= GPC_RST_PLAIN;
      scr2_r <= GPC_RST_PLAIN;
      wctl_r <= GPC_RST_PLAIN;
      amode_r <= GPC_RST_PLAIN;
    end else if (acc_wr && aligned) begin
      unique case (idx)
        GPC_IDX_WAKE_RETURN: wret_r <= {5'h00, avs_writedata[2:0] & GPC_WAKE_RETURN_MASK};
        GPC_IDX_SCRATCH_ONE: scr1_r <= avs_writedata[7:0];
        GPC_IDX_SCRATCH_TWO: scr2_r <= avs_writedata[7:0];
        GPC_IDX_WAKE_CONTROL: wctl_r <= avs_writedata[7:0];
        GPC_IDX_ACTIVITY_MODE: amode_r <= avs_writedata[7:0];
        default: ;
      endcase
    end
  end

  // event status: sticky, cleared by a read, set wins
  assign ev_set = {wake, enter};
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      ev_st_r <= '0;
    end else if (acc_rd && aligned && idx == GPC_IDX_IRQ_STATUS) begin
      // only bits the reader saw are cleared, so an event in the wait cycle survives
      ev_st_r <= (ev_st_r & ~avs_readdata[GPC_EV_W-1:0]) | ev_set;
    end else begin
      ev_st_r <= ev_st_r | ev_set;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      ev_mask_r <= GPC_RST_MASK;
    end else if (acc_wr && aligned && idx == GPC_IDX_IRQ_MASK) begin
      ev_mask_r <= avs_writedata[GPC_EV_W-1:0];
    end
  end
  assign irq_out = |(ev_st_r & ev_mask_r);

  // management interrupt pulse, or line 15 held until the main register is written
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      smi_pulse_r <= 1'b0;
      irq15_r <= 1'b0;
    end else begin
      smi_pulse_r <= (enter || wake) && mode_r[GPC_B_MODE_SEL-4] && mode_r[GPC_B_SMI_EN-4]
                     && !mode_r[GPC_B_IRQ15_EN-4];
      if ((enter || wake) && mode_r[GPC_B_MODE_SEL-4] && mode_r[GPC_B_IRQ15_EN-4]) begin
        irq15_r <= 1'b1;
      end else if (acc_wr && aligned && idx == GPC_IDX_MAIN) begin
        irq15_r <= 1'b0;
      end
    end
  end
  assign system_mgmt_interrupt_out_n = ~smi_pulse_r;
  assign irq15_out = irq15_r;

  // panel power drops in low power only when handling is enabled
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      panel_power_enable_out_n <= 1'b0;
    end else begin
      panel_power_enable_out_n <= mode_r[GPC_B_PANEL_EN-4] && (state_nxt != GPC_ST_NORMAL);
    end
  end

  // read mux; unmapped or unaligned reads return zero
  always_comb begin
    rd_byte = 8'h00;
    if (aligned) begin
      unique case (idx)
        GPC_IDX_MAIN: rd_byte = {mode_r, normal_r, flag_r};
        GPC_IDX_TIMER_CFG: rd_byte = {5'h00, tsel_r};
        GPC_IDX_WAKE_RETURN: rd_byte = wret_r;
        GPC_IDX_SCRATCH_ONE: rd_byte = scr1_r;
        GPC_IDX_SCRATCH_TWO: rd_byte = scr2_r;
        GPC_IDX_WAKE_CONTROL: rd_byte = wctl_r;
        GPC_IDX_ACTIVITY_MODE: rd_byte = amode_r;
        GPC_IDX_IRQ_STATUS: rd_byte = {6'h00, ev_st_r};
        GPC_IDX_IRQ_MASK: rd_byte = {6'h00, ev_mask_r};
        default: rd_byte = 8'h00;
      endcase
    end
  end

  // data captured in the wait cycle, stands through the accept edge
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      avs_readdata <= 32'h00000000;
    end else if (avs_read && !ack_r) begin
      avs_readdata <= {24'h000000, rd_byte};
    end
  end

  default clocking dc @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  sequence s_wake_seen;
    state_r == GPC_ST_LOW && wake;
  endsequence

  sequence s_status_back;
    !normal_r ##1 normal_r;
  endsequence

  wake_status_delay_a: assert property (s_wake_seen |=> s_status_back)
    else $error("status bit not back after the wake delay");
  status_low_entry_a: assert property (enter |=> !normal_r && state_r == GPC_ST_LOW)
    else $error("entry did not clear normal status");
  force_enter_a: assert property (state_r == GPC_ST_NORMAL && force_hit |=> flag_r[GPC_B_FORCE])
    else $error("forced entry did not set its flag");
  force_blocked_a: assert property (!en_r[GPC_B_FORCE] |-> !force_hit)
    else $error("force accepted while disabled");
  ext_flag_a: assert property (state_r == GPC_ST_NORMAL && ext_hit && !force_hit |=> flag_r[GPC_B_EXT])
    else $error("request pin entry not flagged");
  timer_flag_a: assert property (flag_set[GPC_B_TIMER] |-> en_r[GPC_B_TIMER] && secs_r >= GPC_IDLE_SECS[tsel_r])
    else $error("timer flag without expiry");
  flag_hold_a: assert property (flag_r[GPC_B_TIMER] && !(acc_wr && idx == GPC_IDX_MAIN) |=>
                                flag_r[GPC_B_TIMER])
    else $error("timer flag dropped without a write");
  flag_clear_a: assert property (acc_wr && aligned && idx == GPC_IDX_MAIN && !avs_writedata[GPC_B_EXT]
                                 && !flag_set[GPC_B_EXT] |=> !flag_r[GPC_B_EXT] && !en_r[GPC_B_EXT])
    else $error("write 0 did not clear request flag");
  smi_gate_a: assert property (!system_mgmt_interrupt_out_n |-> $past(mode_r[GPC_B_SMI_EN-4])
                               && $past(mode_r[GPC_B_MODE_SEL-4]))
    else $error("management interrupt without enables");
  panel_gate_a: assert property (!mode_r[GPC_B_PANEL_EN-4] |=> !panel_power_enable_out_n)
    else $error("panel power dropped while handling off");
  line15_set_a: assert property (enter && mode_r[GPC_B_MODE_SEL-4] && mode_r[GPC_B_IRQ15_EN-4]
                                 |=> irq15_out && system_mgmt_interrupt_out_n)
    else $error("line 15 substitution failed");
endmodule
`default_nettype wire

// ===== test/gpc_pin_model.sv
`timescale 1ns/1ns
`default_nettype none
// far-side pins; request line idles high as if pulled up
module gpc_pin_model (
  input wire logic clk_sys,
  output logic external_pm_request_in_n,
  output logic wake_event_in,
  output logic activity_in
);
  initial begin
    external_pm_request_in_n = 1'b1;
    wake_event_in = 1'b0;
    activity_in = 1'b0;
  end
  // held n cycles so the two-flop synchroniser cannot miss it
  task automatic pulse(input int which, input int n);
    @(posedge clk_sys);
    case (which)
      0: external_pm_request_in_n <= 1'b0;
      1: wake_event_in <= 1'b1;
      default: activity_in <= 1'b1;
    endcase
    repeat (n) @(posedge clk_sys);
    external_pm_request_in_n <= 1'b1;
    wake_event_in <= 1'b0;
    activity_in <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ===== test/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import gpc_pkg::*;
  typedef struct {logic [9:0] a; logic [7:0] d; logic [7:0] e;} gpc_row_t;
  typedef struct {logic [7:0] c; int smi; logic pan; logic i15;} gpc_mode_t;
  localparam logic [9:0] A_MAIN = {GPC_IDX_MAIN, 2'b00};
  localparam logic [9:0] A_TCFG = {GPC_IDX_TIMER_CFG, 2'b00};
  localparam logic [9:0] A_STAT = {GPC_IDX_IRQ_STATUS, 2'b00};
  localparam logic [9:0] A_MASK = {GPC_IDX_IRQ_MASK, 2'b00};
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic [9:0] avs_address = 10'h000;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic ext_n, wake, act;
  logic panel_n, smi_n, irq15, irq, lps;
  int err_total = 0;
  int n_checks = 0;
  int smi_cnt = 0;
  int s0, k;
  gpc_row_t rows [13] = '{
    '{{GPC_IDX_WAKE_RETURN, 2'b00}, 8'hFF, 8'h07}, '{{GPC_IDX_SCRATCH_ONE, 2'b00}, 8'hA5, 8'hA5},
    '{{GPC_IDX_SCRATCH_TWO, 2'b00}, 8'h5A, 8'h5A}, '{{GPC_IDX_WAKE_CONTROL, 2'b00}, 8'hC3, 8'hC3},
    '{{GPC_IDX_ACTIVITY_MODE, 2'b00}, 8'h3C, 8'h3C}, '{A_MASK, 8'h03, 8'h03},
    '{A_TCFG, 8'h07, 8'h07}, '{A_MAIN, 8'hF7, 8'hF8}, '{A_TCFG, 8'h00, 8'h00},
    '{A_MASK, 8'h00, 8'h00}, '{A_MAIN, 8'h00, 8'h08}, '{10'h000, 8'hFF, 8'h00},
    '{10'h381, 8'hFF, 8'h00}};
  gpc_mode_t modes [3] = '{'{8'h61, 0, 1'b1, 1'b0}, '{8'hA1, 1, 1'b0, 1'b0}, '{8'h91, 0, 1'b0, 1'b1}};

  // timer shortened: one idle second is ten clocks
  gpc_top #(.TICKS_PER_SEC(10)) dut (.clk_sys(clk_sys), .nrst(nrst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .external_pm_request_in_n(ext_n), .wake_event_in(wake), .activity_in(act),
    .panel_power_enable_out_n(panel_n), .system_mgmt_interrupt_out_n(smi_n),
    .irq15_out(irq15), .irq_out(irq), .low_power_state(lps));
  gpc_pin_model pins (.clk_sys(clk_sys), .external_pm_request_in_n(ext_n),
    .wake_event_in(wake), .activity_in(act));

  initial begin
    forever #50 clk_sys = ~clk_sys;
  end
  // count low cycles of the management interrupt pulse
  always @(posedge clk_sys) begin
    if (smi_n === 1'b0) smi_cnt <= smi_cnt + 1;
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // request held until a rising edge samples waitrequest low; data taken at that edge
  task automatic bus(input logic wr, input logic [9:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    @(posedge clk_sys);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= ~wr;
    avs_writedata <= d;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    if (n >= 50) begin
      err_total++;
      stop_test();
    end else begin
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      // later checks look at settled outputs, not the launching edge
      @(negedge clk_sys);
    end
  endtask
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    logic [31:0] q;
    bus(1'b1, a, {24'h0, d}, q);
  endtask
  task automatic rd(input string nm, input logic [9:0] a, input logic [7:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(nm, q, {24'h0, e});
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // hang guard, far above the few hundred cycles the run needs
  initial begin
    repeat (20000) @(posedge clk_sys);
    err_total++;
    stop_test();
  end

  initial begin
    repeat (12) @(posedge clk_sys);
    nrst <= 1'b1;
    cyc(1);
    chk("panel_n", panel_n, 0);
    chk("smi_n", smi_n, 1);
    chk("irq15", irq15, 0);
    chk("irq", irq, 0);
    chk("lps", lps, 0);
    foreach (rows[i]) rd("reset", rows[i].a, rows[i].a == A_MAIN ? 8'h08 : 8'h00);
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      rd("readback", rows[i].a, rows[i].e);
    end
    // force entry in each signalling mode, then wake
    wr(A_MASK, 8'h01);
    foreach (modes[i]) begin
      wr(A_MAIN, modes[i].c);
      s0 = smi_cnt;
      wr(A_TCFG, 8'h08);
      cyc(4);
      chk("lps", lps, 1);
      chk("panel_n", panel_n, modes[i].pan);
      chk("irq15", irq15, modes[i].i15);
      chk("smi", smi_cnt - s0, modes[i].smi);
      chk("irq", irq, 1);
      rd("main", A_MAIN, {modes[i].c[7:4], 4'h1});
      pins.pulse(1, 3);
      cyc(4);
      chk("lps", lps, 0);
      chk("smi", smi_cnt - s0, 2 * modes[i].smi);
      rd("main", A_MAIN, {modes[i].c[7:4], 4'h9});
      rd("stat", A_STAT, 8'h03);
      chk("irq", irq, 0);
      rd("stat", A_STAT, 8'h00);
      wr(A_MAIN, {modes[i].c[7:4], 4'h0});
      chk("irq15", irq15, 0);
      rd("main", A_MAIN, {modes[i].c[7:4], 4'h8});
    end
    // force strobe refused with forced entry disabled
    wr(A_TCFG, 8'h08);
    cyc(4);
    chk("lps", lps, 0);
    // request pin blocked, then allowed with interrupt masked
    pins.pulse(0, 3);
    cyc(6);
    chk("lps", lps, 0);
    wr(A_MASK, 8'h00);
    wr(A_MAIN, 8'h02);
    pins.pulse(0, 3);
    cyc(6);
    chk("lps", lps, 1);
    chk("irq", irq, 0);
    rd("main", A_MAIN, 8'h02);
    rd("stat", A_STAT, 8'h01);
    pins.pulse(1, 3);
    cyc(4);
    chk("lps", lps, 0);
    rd("main", A_MAIN, 8'h0A);
    wr(A_MAIN, 8'h00);
    rd("main", A_MAIN, 8'h08);
    rd("stat", A_STAT, 8'h02);
    // idle timer at code 000: 15 s is 150 clocks here
    wr(A_MAIN, 8'h04);
    cyc(130);
    chk("lps", lps, 0);
    k = 0;
    while (lps !== 1'b1 && k < 60) begin
      cyc(1);
      k++;
    end
    chk("lps", lps, 1);
    rd("main", A_MAIN, 8'h04);
    pins.pulse(2, 3);
    cyc(4);
    chk("lps", lps, 0);
    rd("main", A_MAIN, 8'h0C);
    wr(A_MAIN, 8'h00);
    rd("main", A_MAIN, 8'h08);
    // reset in mid-run from low power brings back the idle values
    wr(A_MAIN, 8'h41);
    wr(A_TCFG, 8'h08);
    chk("lps", lps, 1);
    chk("panel_n", panel_n, 1);
    @(posedge clk_sys);
    nrst <= 1'b0;
    repeat (3) @(posedge clk_sys);
    nrst <= 1'b1;
    cyc(1);
    chk("lps", lps, 0);
    chk("panel_n", panel_n, 0);
    chk("irq15", irq15, 0);
    rd("rst main", A_MAIN, 8'h08);
    rd("rst stat", A_STAT, 8'h00);
    stop_test();
  end
endmodule
`default_nettype wire
